/* hdl/tf_params.svh */
// timing, register offset, field and reset constants of the formatter port
`ifndef TF_PARAMS_SVH
`define TF_PARAMS_SVH
// ============================================================
// clock and interface timing, times in their own unit
`define TF_CLK_MHZ      250
`define TF_CHAR_NS      8000
`define TF_STRB_NS      1000
`define TF_RAMP_US      2000
`define TF_POST_US      500
`define TF_STOP_US      2000
`define TF_FM_ERASE_US  49300
`define TF_CHAR_CYC     ((`TF_CHAR_NS * `TF_CLK_MHZ) / 1000)
`define TF_STRB_CYC     ((`TF_STRB_NS * `TF_CLK_MHZ) / 1000)
`define TF_RAMP_CYC     (`TF_RAMP_US * `TF_CLK_MHZ)
`define TF_POST_CYC     (`TF_POST_US * `TF_CLK_MHZ)
`define TF_STOP_CYC     (`TF_STOP_US * `TF_CLK_MHZ)
`define TF_FM_CYC       (`TF_FM_ERASE_US * `TF_CLK_MHZ)
// ============================================================
// register byte offsets
`define TF_OFS_CTRL     8'h00
`define TF_OFS_STAT     8'h04
`define TF_OFS_CMD      8'h08
`define TF_OFS_CHAR     8'h0C
// ============================================================
// control register fields and reset value
`define TF_CTRL_STRAP   0
`define TF_CTRL_TRK7    1
`define TF_CTRL_SSTK    2
`define TF_CTRL_EXTP    3
`define TF_CTRL_DPR     4
`define TF_CTRL_W       6
`define TF_CTRL_RST     6'h00
// ============================================================
// bus responses
`define TF_RESP_OKAY    2'h0
`define TF_RESP_SLVERR  2'h2
`endif

/* hdl/tf_pkg.sv */
// types shared by the tape formatter command port
package tf_pkg;
  typedef logic [7:0] tf_char_t;
  typedef logic [1:0] tf_slot_t;
  // gray codes along idle, ramp, data, post, stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RAMP = 3'h1,
    ST_DATA = 3'h3,
    ST_POST = 3'h2,
    ST_STOP = 3'h6
  } tf_state_e;
endpackage

/* hdl/tf_sync.sv */
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module tf_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // pins and synchronised copies
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] synced
);
  // ============================================================
  // per bit: first stage feeds only the second
  // idle lines float high, so both stages reset to one
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else begin
        meta_q <= pins[g];
        sync_q <= meta_q;
      end
    end
    assign synced[g] = sync_q;
  end
endmodule

/* hdl/tf_cmd_port.sv */
// tape formatter command port: controller lines in, transport controls out
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tf_params.svh"
// ============================================================
// Function
// - select high is address zero, strap compared
// - only matching formatter drives its lines
// - transport lines decode to four slots
// - go trailing edge latches command, busy low
// - direction low means reverse motion
// - write mode low means write
// - file mark: mark, fixed erase, search
// - edit adjusts stop delay on reverse read, ramps write current
// - erase write is dummy record to last
// - erase write mark erases fixed length
// - erase on search inhibits read strobes
// - single stack threshold one low is high
// - density low selects higher density
// - density taken only at operation start
// - rewind pulse forwarded, no busy
// - offline pulse forwarded, no busy
// - enable high resets all formatters quiescent
// - formatter busy low until motion stops
// - data busy low across data transfer
// - 7-track parity select high odd, low even
module tf_cmd_port #(
  parameter logic [23:0] RAMP_CYC = 24'(`TF_RAMP_CYC),
  parameter logic [23:0] POST_CYC = 24'(`TF_POST_CYC),
  parameter logic [23:0] STOP_CYC = 24'(`TF_STOP_CYC),
  parameter logic [23:0] FM_CYC   = 24'(`TF_FM_CYC)
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // controller command lines, low true unless noted
  input  wire logic             formatter_select,
  input  wire logic             transport_select_0,
  input  wire logic             transport_select_1,
  input  wire logic             initiate_pulse,
  input  wire logic             direction_sel,
  input  wire logic             write_mode_n,
  input  wire logic             file_mark_req,
  input  wire logic             edit_mode,
  input  wire logic             erase_mode,
  input  wire logic             read_threshold_hi,
  input  wire logic             read_threshold_xlow,
  input  wire logic             density_sel,
  input  wire logic             rewind_pulse,
  input  wire logic             offline_pulse,
  input  wire logic             last_char_flag,
  input  wire logic             formatter_reset_level,
  input  wire logic             parity_kind_sel,
  input  wire logic             write_parity_bit,
  input  wire tf_pkg::tf_char_t write_char_bus,
  // formatter to controller
  output logic                  formatter_busy_n,
  output logic                  data_busy_n,
  output logic                  write_demand_strobe,
  // read side, same clock
  input  wire logic             rec_done,
  // transport side
  output tf_pkg::tf_slot_t      slot_sel,
  output logic                  tp_rewind,
  output logic                  tp_offline,
  output logic                  motion_reverse,
  output logic                  op_write,
  output logic                  op_file_mark,
  output logic                  op_file_search,
  output logic                  edit_stop_adj,
  output logic                  edit_ramp_off,
  output logic                  read_strobe_inhibit,
  output logic                  thresh_high,
  output logic                  thresh_xlow,
  output logic                  dens_high,
  output logic                  pe_mode,
  output logic [1:0]            dens_pair,
  output tf_pkg::tf_char_t      rec_char,
  output logic                  rec_parity,
  output logic                  rec_valid,
  // register bus, AXI4-Lite slave
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import tf_pkg::*;

  localparam int NS = 26;
  localparam logic [11:0] CHAR_CYC = 12'(`TF_CHAR_CYC);
  localparam logic [11:0] STRB_CYC = 12'(`TF_STRB_CYC);

  // ============================================================
  // pin synchronisers
  logic [NS-1:0] raw_w;
  logic [NS-1:0] syn_w;
  logic s_fsel, s_t0, s_t1, s_go, s_rev, s_wrt, s_fm, s_edit;
  logic s_era, s_thr1, s_thr2, s_den, s_rew, s_ofl, s_lwd, s_fen;
  logic s_par, s_wdp;
  tf_char_t s_wd;

  assign raw_w = {formatter_select, transport_select_0, transport_select_1,
                  initiate_pulse, direction_sel, write_mode_n, file_mark_req,
                  edit_mode, erase_mode, read_threshold_hi, read_threshold_xlow,
                  density_sel, rewind_pulse, offline_pulse, last_char_flag,
                  formatter_reset_level, parity_kind_sel, write_parity_bit,
                  write_char_bus};

  tf_sync #(.W(NS)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pins     (raw_w),
    .synced   (syn_w)
  );

  assign {s_fsel, s_t0, s_t1, s_go, s_rev, s_wrt, s_fm, s_edit,
          s_era, s_thr1, s_thr2, s_den, s_rew, s_ofl, s_lwd, s_fen,
          s_par, s_wdp, s_wd} = syn_w;

  // ============================================================
  // selection and command capture
  logic [`TF_CTRL_W-1:0] ctrl_q;
  logic      sel_w;
  logic      go_prev_q;
  logic      go_rise;
  logic      capture_w;
  tf_state_e st_q;

  // line high means address zero, strap bit holds own address
  assign sel_w = (~s_fsel) == ctrl_q[`TF_CTRL_STRAP];
  // go is low true, so its trailing edge is the rise
  assign go_rise = s_go & ~go_prev_q;
  // captures outside the ramp and data states; on-the-fly after data
  assign capture_w = go_rise & sel_w & ~s_fen
                   & (st_q != ST_RAMP) & (st_q != ST_DATA);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_prev_q <= 1'b1;
    end else begin
      go_prev_q <= s_go;
    end
  end

  // latched command, stored as true-high
  logic rev_q, wr_q, fm_q, edit_q, era_q, thr1_q, thr2_q, den_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {rev_q, wr_q, fm_q, edit_q, era_q, thr1_q, thr2_q, den_q} <= 8'h00;
    end else if (s_fen) begin
      {rev_q, wr_q, fm_q, edit_q, era_q, thr1_q, thr2_q, den_q} <= 8'h00;
    end else if (capture_w) begin
      rev_q  <= ~s_rev;
      wr_q   <= ~s_wrt;
      fm_q   <= ~s_fm;
      edit_q <= ~s_edit;
      era_q  <= ~s_era;
      thr1_q <= ~s_thr1;
      thr2_q <= ~s_thr2;
      den_q  <= ~s_den;
    end
  end

  // ============================================================
  // operation sequencer
  logic [23:0] tmr_q;
  logic        fbn_q;
  logic        dbn_q;
  logic        data_end_w;
  logic        samp_w;
  logic        fixed_w;

  // mark writes and fixed erase run for a timed length
  assign fixed_w = wr_q & fm_q;
  assign data_end_w = fixed_w ? (tmr_q >= FM_CYC - 24'd1)
                    : wr_q ? (samp_w & ~s_lwd)
                    : rec_done;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_IDLE;
      tmr_q <= '0;
      fbn_q <= 1'b1;
      dbn_q <= 1'b1;
    end else if (s_fen) begin
      st_q  <= ST_IDLE;
      tmr_q <= '0;
      fbn_q <= 1'b1;
      dbn_q <= 1'b1;
    end else if (capture_w) begin
      st_q  <= ST_RAMP;
      tmr_q <= '0;
      fbn_q <= 1'b0;
      dbn_q <= 1'b1;
    end else begin
      tmr_q <= tmr_q + 24'd1;
      unique case (st_q)
        ST_IDLE: begin
          tmr_q <= '0;
        end
        ST_RAMP: begin
          if (tmr_q >= RAMP_CYC - 24'd1) begin
            st_q  <= ST_DATA;
            tmr_q <= '0;
            dbn_q <= 1'b0;
          end
        end
        ST_DATA: begin
          if (data_end_w) begin
            st_q  <= ST_POST;
            tmr_q <= '0;
          end
        end
        ST_POST: begin
          if (tmr_q >= POST_CYC - 24'd1) begin
            st_q  <= ST_STOP;
            tmr_q <= '0;
            dbn_q <= 1'b1;
          end
        end
        ST_STOP: begin
          if (tmr_q >= STOP_CYC - 24'd1) begin
            st_q  <= ST_IDLE;
            tmr_q <= '0;
            fbn_q <= 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // write demand strobes and character sampling
  logic [11:0] ctmr_q;
  logic        strb_q;
  logic        strb_d;
  logic        wdata_w;
  tf_char_t    chr_w;
  logic        gen_par_w;
  logic        odd_w;

  assign wdata_w = (st_q == ST_DATA) & wr_q & ~fm_q;
  // first strobe ends one period after data busy falls
  assign strb_d = wdata_w & (ctmr_q >= CHAR_CYC - STRB_CYC);
  assign samp_w = wdata_w & strb_q & ~strb_d;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctmr_q <= '0;
      strb_q <= 1'b0;
    end else if (!wdata_w || s_fen) begin
      ctmr_q <= '0;
      strb_q <= 1'b0;
    end else begin
      ctmr_q <= (ctmr_q == CHAR_CYC - 12'd1) ? 12'd0 : ctmr_q + 12'd1;
      strb_q <= strb_d;
    end
  end

  // 7-track ignores the two low data lines
  assign chr_w = ctrl_q[`TF_CTRL_TRK7] ? {s_wd[7:2], 2'b00} : s_wd;
  assign odd_w = ctrl_q[`TF_CTRL_TRK7] ? s_par : 1'b1;
  assign gen_par_w = ~(^chr_w) ^ ~odd_w;

  // dummy erase records run the strobes but record nothing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_char   <= '0;
      rec_parity <= 1'b0;
      rec_valid  <= 1'b0;
    end else begin
      rec_valid <= samp_w & ~era_q;
      if (samp_w & ~era_q) begin
        rec_char   <= chr_w;
        rec_parity <= ctrl_q[`TF_CTRL_EXTP] ? s_wdp : gen_par_w;
      end
    end
  end

  // ============================================================
  // direct pulses and slot decode; busy is never touched here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_sel   <= 2'h0;
      tp_rewind  <= 1'b0;
      tp_offline <= 1'b0;
    end else begin
      slot_sel   <= {~s_t0, ~s_t1};
      tp_rewind  <= sel_w & ~s_rew & ~s_fen;
      tp_offline <= sel_w & ~s_ofl & ~s_fen;
    end
  end

  // command meanings toward the transport
  assign motion_reverse      = rev_q;
  assign op_write            = wr_q & ~era_q;
  assign op_file_mark        = wr_q & fm_q & ~era_q;
  assign op_file_search      = ~wr_q & fm_q;
  assign edit_stop_adj       = edit_q & rev_q & ~wr_q;
  assign edit_ramp_off       = edit_q & wr_q;
  assign read_strobe_inhibit = ~wr_q & era_q;
  assign thresh_high = ctrl_q[`TF_CTRL_SSTK] & thr1_q;
  assign thresh_xlow         = thr2_q;
  assign dens_high           = den_q;
  assign pe_mode = ~ctrl_q[`TF_CTRL_TRK7] & den_q;
  assign dens_pair           = ctrl_q[`TF_CTRL_DPR+:2];

  // an unselected formatter keeps its busy and strobe lines idle
  assign formatter_busy_n    = fbn_q | ~sel_w;
  assign data_busy_n         = dbn_q | ~sel_w;
  assign write_demand_strobe = strb_q & sel_w;

  // ============================================================
  // register slave
  logic        aw_ok_q, w_ok_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] rd_w;
  logic        rd_hit_w;

  // one write at a time: both halves held until the response
  assign s_axi_awready = ~aw_ok_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ok_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_q      <= 1'b0;
      w_ok_q       <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_ok_q  <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_ok_q  <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_ok_q & w_ok_q) begin
        aw_ok_q      <= 1'b0;
        w_ok_q       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[7:2] == 6'(`TF_OFS_CTRL >> 2))
                        ? `TF_RESP_OKAY : `TF_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register: strap address, track count, head, parity, densities
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TF_CTRL_RST;
    end else if (aw_ok_q & w_ok_q & wstrb_q[0]
                 & (awaddr_q[7:2] == 6'(`TF_OFS_CTRL >> 2))) begin
      ctrl_q <= wdata_q[`TF_CTRL_W-1:0];
    end
  end

  // read mux; the status word shows the sequencer itself
  always_comb begin
    rd_w     = 32'h0000_0000;
    rd_hit_w = 1'b1;
    unique case (s_axi_araddr[7:2])
      6'(`TF_OFS_CTRL >> 2): rd_w = {26'h0, ctrl_q};
      6'(`TF_OFS_STAT >> 2): rd_w = {24'h0, st_q, slot_sel, sel_w, ~dbn_q, ~fbn_q};
      6'(`TF_OFS_CMD >> 2):  rd_w = {24'h0, den_q, thr2_q, thr1_q, era_q,
                                     edit_q, fm_q, wr_q, rev_q};
      6'(`TF_OFS_CHAR >> 2): rd_w = {23'h0, rec_parity, rec_char};
      default:           rd_hit_w = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `TF_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_w;
      s_axi_rresp  <= rd_hit_w ? `TF_RESP_OKAY : `TF_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_post_high;
    (st_q == ST_POST) ##1 (st_q == ST_POST);
  endsequence

  sequence s_idle_rewind;
    (st_q == ST_IDLE) && !s_rew && !capture_w && fbn_q;
  endsequence

  AST_CAPTURE_BUSY: assert property (
    capture_w |=> !fbn_q && st_q == ST_RAMP)
    else $error("capture did not set busy");

  AST_UNSELECTED: assert property (
    go_rise && !sel_w && st_q == ST_IDLE |=> fbn_q)
    else $error("unselected formatter went busy");

  AST_SLOT_DECODE: assert property (
    !s_t0 && !s_t1 |=> slot_sel == 2'h3)
    else $error("slot decode wrong");

  AST_QUIET: assert property (
    s_fen |=> st_q == ST_IDLE && fbn_q && dbn_q && !strb_q)
    else $error("enable level did not quiesce");

  AST_DEN_HOLD: assert property (
    !capture_w && !s_fen |=> $stable(den_q))
    else $error("density changed mid operation");

  AST_REWIND_NOBUSY: assert property (
    s_idle_rewind |=> fbn_q)
    else $error("rewind made formatter busy");

  AST_LAST_CHAR: assert property (
    st_q == ST_DATA && samp_w && !s_lwd && wr_q && !fixed_w |=> s_post_high)
    else $error("last character did not end data");

  AST_ERASE_NOREC: assert property (
    era_q |-> !rec_valid)
    else $error("dummy record wrote data");

  AST_DATA_BUSY: assert property (
    (st_q == ST_DATA) |-> !dbn_q ##0 $past(st_q) != ST_STOP)
    else $error("data busy high in data phase");

  AST_NO_GO_IN_DATA: assert property (
    st_q == ST_DATA && go_rise && !s_fen |=> st_q != ST_RAMP)
    else $error("command taken while data busy");
endmodule

/* bench/tf_ctl_model.sv */
// controller model: write characters paced by the demand strobe
`timescale 1ns/100ps
module tf_ctl_model (
  // clock and handshake
  input  wire logic        core_clk,
  input  wire logic        write_demand_strobe,
  input  wire logic        data_busy_n,
  input  wire logic [7:0]  rec_len,
  // write data pins
  output tf_pkg::tf_char_t write_char_bus,
  output logic             write_parity_bit,
  output logic             last_char_flag
);
  import tf_pkg::*;
  logic [7:0] idx_q  = 8'h00;
  logic       strb_q = 1'h0;
  tf_char_t   chr;
  // char k is 3c plus 1d times k; idle bus shows the inverse, never a held value
  assign chr              = 8'h3c + idx_q * 8'h1d;
  assign write_char_bus   = data_busy_n ? ~chr : chr;
  assign write_parity_bit = ~^write_char_bus;
  assign last_char_flag   = ~(~data_busy_n && idx_q == rec_len - 8'h01);
  // next char only after the strobe ends, well inside half a period
  always_ff @(posedge core_clk) begin
    strb_q <= write_demand_strobe;
    if (data_busy_n) idx_q <= 8'h00;
    else if (strb_q && !write_demand_strobe) idx_q <= idx_q + 8'h01;
  end
endmodule

/* bench/tf_cmd_port_tb.sv */
// self-checking bench of the formatter command port
`timescale 1ns/100ps
module tf_cmd_port_tb;
  import tf_pkg::*;
  // ============================================================
  // pins and bus
  logic core_clk = 1'h0, rst_n = 1'h0, rec_done = 1'h0, formatter_reset_level = 1'h0;
  logic formatter_select = 1'h1, transport_select_0 = 1'h1, transport_select_1 = 1'h1;
  logic initiate_pulse = 1'h1, rewind_pulse = 1'h1, offline_pulse = 1'h1;
  logic direction_sel = 1'h1, write_mode_n = 1'h1, file_mark_req = 1'h1, edit_mode = 1'h1;
  logic erase_mode = 1'h1, read_threshold_hi = 1'h1, read_threshold_xlow = 1'h1;
  logic density_sel = 1'h1, parity_kind_sel = 1'h1, write_parity_bit, last_char_flag;
  logic formatter_busy_n, data_busy_n, write_demand_strobe, tp_rewind, tp_offline;
  logic motion_reverse, op_write, op_file_mark, op_file_search, edit_stop_adj, edit_ramp_off;
  logic read_strobe_inhibit, thresh_high, thresh_xlow, dens_high, pe_mode, rec_parity;
  logic rec_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0]  dens_pair, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rec_len = 8'h03;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [9:0]  decv;
  tf_char_t    write_char_bus, rec_char, ex;
  tf_slot_t    slot_sel;
  int          mismatches = 0, checks = 0, k, nstb = 0;
  assign decv = {motion_reverse, op_write, op_file_mark, op_file_search, edit_stop_adj,
                 read_strobe_inhibit, thresh_high, thresh_xlow, dens_high, pe_mode};
  // short counts keep the run brief
  tf_cmd_port #(.RAMP_CYC(24'h00_0014), .POST_CYC(24'h00_000a), .STOP_CYC(24'h00_0014),
    .FM_CYC(24'h00_0032)) i_dut (.*);
  tf_ctl_model i_ctl (.*);
  // 250 MHz clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // ============================================================
  // report and compare
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic hang();
    fail("wait ran out");
    print_verdict();
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) fail(m);
  endtask
  // bounded wait on a busy line, zero picks formatter busy
  task automatic wait_pin(input bit dbusy, input logic v, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge core_clk);
      if ((dbusy ? data_busy_n : formatter_busy_n) === v) return;
    end
    hang();
  endtask
  // ============================================================
  // bus and pin drivers
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  // lines settle, then a go pulse of 64 cycles, lines held after it
  task automatic go(input logic [7:0] c);
    {density_sel, read_threshold_xlow, read_threshold_hi, erase_mode, edit_mode,
     file_mark_req, write_mode_n, direction_sel} <= c;
    repeat (64) @(posedge core_clk);
    initiate_pulse <= 1'h0;
    repeat (64) @(posedge core_clk);
    initiate_pulse <= 1'h1;
    repeat (64) @(posedge core_clk);
  endtask
  // rewind or off-line pulse passes straight through
  task automatic side_pulse(input bit off);
    if (off) offline_pulse <= 1'h0;
    else rewind_pulse <= 1'h0;
    repeat (56) @(posedge core_clk);
    chk_bit(off ? tp_offline : tp_rewind, 1'h1, "pulse not passed");
    chk_bit(formatter_busy_n, 1'h1, "pulse set busy");
    rewind_pulse  <= 1'h1;
    offline_pulse <= 1'h1;
    repeat (8) @(posedge core_clk);
    chk_bit(off ? tp_offline : tp_rewind, 1'h0, "pulse stuck");
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge core_clk);
    chk_bit(formatter_busy_n & data_busy_n, 1'h1, "busy after reset");
    axi_rd(8'h00, rd, rsp);
    chk_word(rd, 32'h0000_0000, "control reset value");
    axi_wr(8'h04, 32'h0000_00ff, rsp);
    chk_word(32'(rsp), 32'h0000_0002, "status write taken");
    axi_rd(8'h10, rd, rsp);
    chk_word({rd[29:0], rsp}, 32'h0000_0002, "unmapped read");
    // strap address one, single stack head, density pair one
    axi_wr(8'h00, 32'h0000_0015, rsp);
    axi_rd(8'h00, rd, rsp);
    chk_word(rd, 32'h0000_0015, "control readback");
    chk_word(32'(dens_pair), 32'h0000_0001, "density straps");
    for (int i = 0; i < 4; i++) begin
      transport_select_0 <= ~i[1]; // changed only while idle
      transport_select_1 <= ~i[0];
      repeat (6) @(posedge core_clk);
      chk_word(32'(slot_sel), 32'(i), "slot decode");
    end
    // high select means address zero, so this go is foreign
    go(8'h82);
    chk_bit(formatter_busy_n, 1'h1, "foreign go taken");
    formatter_select <= 1'h0;
    side_pulse(1'b0);
    side_pulse(1'b1);
    go(8'h82);
    chk_bit(formatter_busy_n, 1'h0, "read not started");
    chk_word(32'(decv), 32'h0000_027c, "read decode");
    wait_pin(1'b1, 1'h0, 100);
    // a go inside the data phase must be ignored
    initiate_pulse <= 1'h0;
    repeat (64) @(posedge core_clk);
    initiate_pulse <= 1'h1;
    repeat (64) @(posedge core_clk);
    chk_bit(data_busy_n, 1'h0, "go taken in data phase");
    rec_done <= 1'h1;
    @(posedge core_clk);
    rec_done <= 1'h0;
    wait_pin(1'b1, 1'h1, 100);
    chk_bit(formatter_busy_n, 1'h0, "busy dropped early");
    wait_pin(1'b0, 1'h1, 100);
    // three-char write; density moved mid-run must not take
    go(8'h75);
    chk_word(32'(decv), 32'h0000_0103, "write decode");
    chk_bit(edit_ramp_off, 1'h1, "edit ramp");
    density_sel <= 1'h1;
    k = 0;
    for (int n = 0; n < 8000 && k < 3; n++) begin
      @(posedge core_clk);
      if (write_demand_strobe === 1'h1) nstb++;
      if (rec_valid === 1'h1) begin
        ex = 8'h3c + 8'(k) * 8'h1d;
        chk_word({23'h0, rec_parity, rec_char}, {23'h0, ~^ex, ex}, "write char");
        k++;
      end
    end
    chk_word(32'(k), 32'h0000_0003, "char count");
    chk_word(32'(nstb), 32'h0000_02ee, "strobe cycles");
    chk_bit(dens_high, 1'h1, "density changed mid-run");
    wait_pin(1'b1, 1'h1, 2500);
    wait_pin(1'b0, 1'h1, 100);
    // dummy mark write: fixed erase, nothing recorded
    go(8'he9);
    chk_word(32'(decv), 32'h0000_0000, "erase decode");
    wait_pin(1'b1, 1'h1, 100);
    chk_word(32'(rec_char), 32'h0000_0076, "erase recorded");
    wait_pin(1'b0, 1'h1, 100);
    // enable level aborts a read in its data phase
    go(8'h82);
    formatter_reset_level <= 1'h1;
    repeat (8) @(posedge core_clk);
    chk_bit(formatter_busy_n & data_busy_n, 1'h1, "enable level reset");
    formatter_reset_level <= 1'h0;
    repeat (8) @(posedge core_clk);
    print_verdict();
  end
endmodule
